// ### rtl/esd_pkg.sv
package esd_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_REG1_DELAY = 8'h0f;
   localparam logic [7:0] ADDR_AUX1_DELAY = 8'h10;
   localparam logic [7:0] ADDR_AUX2_DELAY = 8'h11;
   localparam logic [7:0] ADDR_OUT_CTRL = 8'h12;
   localparam logic [7:0] ADDR_CONFIG = 8'h13;
   // Reset values and output control write mask
   localparam logic [7:0] RST_REG1_DELAY = 8'h25;
   localparam logic [7:0] RST_AUX1_DELAY = 8'h07;
   localparam logic [7:0] RST_AUX2_DELAY = 8'h0a;
   localparam logic [7:0] RST_OUT_CTRL = 8'h77;
   localparam logic [7:0] RST_CONFIG = 8'h06;
   localparam logic [7:0] OUT_CTRL_WMASK = 8'h77;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // Delay register fields
   localparam int FALL_MSB = 7;
   localparam int FALL_LSB = 4;
   localparam int RISE_MSB = 3;
   localparam int RISE_LSB = 0;
   localparam int CODE_W = 4;
   localparam int STEPS_W = 5;
   // Output control fields
   localparam int AUX1_LEVEL_BIT = 0;
   localparam int AUX1_GATE_BIT = 1;
   localparam int AUX1_DRIVE_BIT = 2;
   localparam int AUX2_LEVEL_BIT = 4;
   localparam int AUX2_GATE_BIT = 5;
   localparam int AUX2_DRIVE_BIT = 6;
   // Configuration fields
   localparam int SPREAD_BIT = 0;
   localparam int THERM_BIT = 1;
   localparam int ENABLE_PIN_PULLDOWN_BIT = 2;
   localparam int SHARED_PD_BIT = 3;
   localparam int PIN_FUNC_BIT = 4;
   localparam int FALL_RANGE_BIT = 5;
   localparam int RISE_RANGE_BIT = 6;
   // Channels
   localparam int NUM_CHAN = 3;
   localparam int CH_REG1 = 0;
   localparam int CH_AUX1 = 1;
   localparam int CH_AUX2 = 2;
   // Timebase
   localparam int CLK_MHZ = 40;
   localparam int STEP_US = 500;
   localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
   localparam int TICK_W = 16;
   typedef enum logic [3:0] {
      CH_OFF = 4'h1,
      CH_WAIT_ON = 4'h2,
      CH_ON = 4'h4,
      CH_WAIT_OFF = 4'h8
   } esd_chan_e;
endpackage

// ### rtl/esd_delay_chan.sv
`timescale 1ns/1ps
module esd_delay_chan
   import esd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Enable edges and timebase
   input wire logic rise_i,
   input wire logic fall_i,
   input wire logic tick_i,
   // Delay setup
   input wire logic [CODE_W-1:0] rise_code_i,
   input wire logic [CODE_W-1:0] fall_code_i,
   input wire logic rise_range_i,
   input wire logic fall_range_i,
   // Sequenced level
   output logic seq_o
);
   esd_chan_e state_reg, state_next;
   logic [STEPS_W-1:0] cnt_reg, cnt_next;
   logic [STEPS_W-1:0] rise_steps, fall_steps;

   // Code counted in whole-step ticks, doubled when the range bit is set
   assign rise_steps = rise_range_i ? {rise_code_i, 1'b0} : {1'b0, rise_code_i};
   assign fall_steps = fall_range_i ? {fall_code_i, 1'b0} : {1'b0, fall_code_i};

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      // Output already at the new level stays there, no glitch
      if (rise_i) begin
         cnt_next = rise_steps;
         state_next = ((rise_steps == '0) || seq_o) ? CH_ON : CH_WAIT_ON;
      end else if (fall_i) begin
         cnt_next = fall_steps;
         state_next = ((fall_steps == '0) || !seq_o) ? CH_OFF : CH_WAIT_OFF;
      end else begin
         case (state_reg)
            CH_WAIT_ON: begin
               if (tick_i) begin
                  cnt_next = cnt_reg - 1'b1;
                  if (cnt_reg == STEPS_W'(1)) begin
                     state_next = CH_ON;
                  end
               end
            end
            CH_WAIT_OFF: begin
               if (tick_i) begin
                  cnt_next = cnt_reg - 1'b1;
                  if (cnt_reg == STEPS_W'(1)) begin
                     state_next = CH_OFF;
                  end
               end
            end
            CH_OFF, CH_ON: begin
               cnt_next = cnt_reg;
            end
            default: begin
               state_next = CH_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= CH_OFF;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // High while on or still waiting to turn off
   assign seq_o = (state_reg == CH_ON) || (state_reg == CH_WAIT_OFF);
endmodule

// ### rtl/esd_seq_top.sv
`timescale 1ns/1ps
module esd_seq_top
   import esd_pkg::*;
#(
   parameter int STEP_CYCLES_P = STEP_CYCLES
) (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   // Enable pin
   input wire logic ENABLE_PIN_I,
   // Register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   // Sequenced outputs
   output logic LINEAR_REG_1_EN_O,
   output logic AUX_OUTPUT_1_O,
   output logic AUX_OUTPUT_1_OE_O,
   output logic AUX_OUTPUT_2_O,
   output logic AUX_OUTPUT_2_OE_O,
   // Configuration outputs
   output logic SHARED_PIN_FUNCTION_O,
   output logic ENABLE_PIN_PULLDOWN_O,
   output logic SHARED_PIN_PULLDOWN_O,
   output logic THERMAL_WARN_THRESHOLD_O,
   output logic SPREAD_SWITCHING_ENABLE_O
);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES_P - 1);

   logic rst_meta_reg, rst_n;
   logic [7:0] reg1_delay_reg, reg1_delay_next;
   logic [7:0] aux1_delay_reg, aux1_delay_next;
   logic [7:0] aux2_delay_reg, aux2_delay_next;
   logic [7:0] out_ctrl_reg, out_ctrl_next;
   logic [7:0] config_reg, config_next;
   logic [7:0] rdata_reg, rdata_next;
   logic en_prev_reg, en_prev_next;
   logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic aux1_reg, aux1_next, aux1_oe_reg, aux1_oe_next;
   logic aux2_reg, aux2_next, aux2_oe_reg, aux2_oe_next;
   logic reg1_en_reg, reg1_en_next;
   logic rise_edge, fall_edge, tick;
   logic aux1_val, aux2_val;
   logic [NUM_CHAN-1:0] seq;
   logic [7:0] dly [NUM_CHAN];

   // Reset release
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Enable edges and timebase
   assign rise_edge = ENABLE_PIN_I && !en_prev_reg;
   assign fall_edge = !ENABLE_PIN_I && en_prev_reg;
   assign tick = (tick_cnt_reg == TICK_LAST);

   always_comb begin
      en_prev_next = ENABLE_PIN_I;
      if (rise_edge || fall_edge) begin
         tick_cnt_next = '0;
      end else if (tick) begin
         tick_cnt_next = '0;
      end else begin
         tick_cnt_next = tick_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         en_prev_reg <= 1'b0;
         tick_cnt_reg <= '0;
      end else begin
         en_prev_reg <= en_prev_next;
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // Delay channels
   assign dly[CH_REG1] = reg1_delay_reg;
   assign dly[CH_AUX1] = aux1_delay_reg;
   assign dly[CH_AUX2] = aux2_delay_reg;

   generate
      for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
         esd_delay_chan u_chan (
            .clk_i(MCLK_I),
            .rst_n_i(rst_n),
            .rise_i(rise_edge),
            .fall_i(fall_edge),
            .tick_i(tick),
            .rise_code_i(dly[c][RISE_MSB:RISE_LSB]),
            .fall_code_i(dly[c][FALL_MSB:FALL_LSB]),
            .rise_range_i(config_reg[RISE_RANGE_BIT]),
            .fall_range_i(config_reg[FALL_RANGE_BIT]),
            .seq_o(seq[c])
         );
      end
   endgenerate

   // Register writes and reads
   always_comb begin
      reg1_delay_next = reg1_delay_reg;
      aux1_delay_next = aux1_delay_reg;
      aux2_delay_next = aux2_delay_reg;
      out_ctrl_next = out_ctrl_reg;
      config_next = config_reg;
      rdata_next = rdata_reg;
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            ADDR_REG1_DELAY: reg1_delay_next = REG_WDATA_I;
            ADDR_AUX1_DELAY: aux1_delay_next = REG_WDATA_I;
            ADDR_AUX2_DELAY: aux2_delay_next = REG_WDATA_I;
            ADDR_OUT_CTRL: out_ctrl_next = REG_WDATA_I & OUT_CTRL_WMASK;
            ADDR_CONFIG: config_next = REG_WDATA_I;
            default: config_next = config_reg;
         endcase
      end
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            ADDR_REG1_DELAY: rdata_next = reg1_delay_reg;
            ADDR_AUX1_DELAY: rdata_next = aux1_delay_reg;
            ADDR_AUX2_DELAY: rdata_next = aux2_delay_reg;
            ADDR_OUT_CTRL: rdata_next = out_ctrl_reg;
            ADDR_CONFIG: rdata_next = config_reg;
            default: rdata_next = UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         reg1_delay_reg <= RST_REG1_DELAY;
         aux1_delay_reg <= RST_AUX1_DELAY;
         aux2_delay_reg <= RST_AUX2_DELAY;
         out_ctrl_reg <= RST_OUT_CTRL;
         config_reg <= RST_CONFIG;
         rdata_reg <= UNMAPPED_DATA;
      end else begin
         reg1_delay_reg <= reg1_delay_next;
         aux1_delay_reg <= aux1_delay_next;
         aux2_delay_reg <= aux2_delay_next;
         out_ctrl_reg <= out_ctrl_next;
         config_reg <= config_next;
         rdata_reg <= rdata_next;
      end
   end

   // Pin levels and drivers
   assign aux1_val = out_ctrl_reg[AUX1_LEVEL_BIT] && (!out_ctrl_reg[AUX1_GATE_BIT] || seq[CH_AUX1]);
   assign aux2_val = out_ctrl_reg[AUX2_LEVEL_BIT] && (!out_ctrl_reg[AUX2_GATE_BIT] || seq[CH_AUX2]);

   always_comb begin
      reg1_en_next = seq[CH_REG1];
      aux1_next = out_ctrl_reg[AUX1_DRIVE_BIT] ? 1'b0 : aux1_val;
      aux1_oe_next = out_ctrl_reg[AUX1_DRIVE_BIT] ? !aux1_val : 1'b1;
      if (config_reg[PIN_FUNC_BIT]) begin
         aux2_next = 1'b0;
         aux2_oe_next = 1'b0;
      end else begin
         aux2_next = out_ctrl_reg[AUX2_DRIVE_BIT] ? 1'b0 : aux2_val;
         aux2_oe_next = out_ctrl_reg[AUX2_DRIVE_BIT] ? !aux2_val : 1'b1;
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         reg1_en_reg <= 1'b0;
         aux1_reg <= 1'b0;
         aux1_oe_reg <= 1'b0;
         aux2_reg <= 1'b0;
         aux2_oe_reg <= 1'b0;
      end else begin
         reg1_en_reg <= reg1_en_next;
         aux1_reg <= aux1_next;
         aux1_oe_reg <= aux1_oe_next;
         aux2_reg <= aux2_next;
         aux2_oe_reg <= aux2_oe_next;
      end
   end

   assign REG_RDATA_O = rdata_reg;
   assign LINEAR_REG_1_EN_O = reg1_en_reg;
   assign AUX_OUTPUT_1_O = aux1_reg;
   assign AUX_OUTPUT_1_OE_O = aux1_oe_reg;
   assign AUX_OUTPUT_2_O = aux2_reg;
   assign AUX_OUTPUT_2_OE_O = aux2_oe_reg;
   assign SHARED_PIN_FUNCTION_O = config_reg[PIN_FUNC_BIT];
   assign ENABLE_PIN_PULLDOWN_O = config_reg[ENABLE_PIN_PULLDOWN_BIT];
   assign SHARED_PIN_PULLDOWN_O = config_reg[SHARED_PD_BIT];
   assign THERMAL_WARN_THRESHOLD_O = config_reg[THERM_BIT];
   assign SPREAD_SWITCHING_ENABLE_O = config_reg[SPREAD_BIT];

   // Checks
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!rst_n);

   property p_reg1_fast_off;
      fall_edge && seq[CH_REG1] && (reg1_delay_reg[FALL_MSB:FALL_LSB] == 4'h0) |=> !seq[CH_REG1] ##1 !LINEAR_REG_1_EN_O;
   endproperty
   a_reg1_fast_off: assert property (p_reg1_fast_off)
      else $error("regulator 1 not off at once on zero fall code");

   property p_reg1_waits_on;
      rise_edge && !seq[CH_REG1] && (reg1_delay_reg[RISE_MSB:RISE_LSB] != 4'h0) |=> !seq[CH_REG1] [*4];
   endproperty
   a_reg1_waits_on: assert property (p_reg1_waits_on)
      else $error("regulator 1 turned on before its delay");

   property p_aux1_fast_off;
      fall_edge && (aux1_delay_reg[FALL_MSB:FALL_LSB] == 4'h0) |=> !seq[CH_AUX1];
   endproperty
   a_aux1_fast_off: assert property (p_aux1_fast_off)
      else $error("aux 1 sequence not low on zero fall code");

   property p_aux1_fast_on;
      rise_edge && (aux1_delay_reg[RISE_MSB:RISE_LSB] == 4'h0) |=> seq[CH_AUX1]
         ##1 (AUX_OUTPUT_1_O || $past(out_ctrl_reg[AUX1_DRIVE_BIT]) || !$past(out_ctrl_reg[AUX1_LEVEL_BIT]));
   endproperty
   a_aux1_fast_on: assert property (p_aux1_fast_on)
      else $error("aux 1 not high two cycles after rise with zero code");

   property p_aux2_fast_off;
      fall_edge && (aux2_delay_reg[FALL_MSB:FALL_LSB] == 4'h0) |=> !seq[CH_AUX2];
   endproperty
   a_aux2_fast_off: assert property (p_aux2_fast_off)
      else $error("aux 2 sequence not low on zero fall code");

   property p_tick_restart;
      rise_edge || fall_edge |=> tick_cnt_reg == '0;
   endproperty
   a_tick_restart: assert property (p_tick_restart)
      else $error("timebase not restarted by enable edge");

   property p_aux1_ungated;
      !out_ctrl_reg[AUX1_GATE_BIT] && !out_ctrl_reg[AUX1_DRIVE_BIT] |=> AUX_OUTPUT_1_O == $past(out_ctrl_reg[AUX1_LEVEL_BIT]);
   endproperty
   a_aux1_ungated: assert property (p_aux1_ungated)
      else $error("ungated aux 1 does not follow its level");

   property p_aux2_gated_low;
      !config_reg[PIN_FUNC_BIT] && out_ctrl_reg[AUX2_GATE_BIT] && !out_ctrl_reg[AUX2_DRIVE_BIT] && !seq[CH_AUX2]
         |=> !AUX_OUTPUT_2_O;
   endproperty
   a_aux2_gated_low: assert property (p_aux2_gated_low)
      else $error("gated aux 2 high while sequence low");

   property p_aux1_open_drain;
      out_ctrl_reg[AUX1_DRIVE_BIT] |=> !AUX_OUTPUT_1_O && (AUX_OUTPUT_1_OE_O != $past(aux1_val));
   endproperty
   a_aux1_open_drain: assert property (p_aux1_open_drain)
      else $error("aux 1 open-drain drive wrong");

   property p_shared_pin_clock;
      config_reg[PIN_FUNC_BIT] |=> !AUX_OUTPUT_2_OE_O;
   endproperty
   a_shared_pin_clock: assert property (p_shared_pin_clock)
      else $error("shared pin driven while a clock input");

   property p_pulldown_write;
      REG_WR_I && (REG_ADDR_I == ADDR_CONFIG) |=> ENABLE_PIN_PULLDOWN_O == $past(REG_WDATA_I[ENABLE_PIN_PULLDOWN_BIT]);
   endproperty
   a_pulldown_write: assert property (p_pulldown_write)
      else $error("enable pull-down not taken from config write");

   c_reg1_on: cover property (rise_edge ##[1:1000] seq[CH_REG1]);
   c_reg1_off: cover property (fall_edge ##[1:1000] !seq[CH_REG1]);
   c_restart: cover property (rise_edge ##[1:200] fall_edge);
endmodule

// ### verif/esd_load_model.sv
`timescale 1ns/1ps
module esd_load_model (
   // Enable source
   input wire logic en_req_i,
   output logic en_pin_o,
   // Aux pins from the device
   input wire logic aux1_i,
   input wire logic aux1_oe_i,
   input wire logic aux2_i,
   input wire logic aux2_oe_i,
   // Level seen by the loads
   output logic aux1_lvl_o,
   output logic aux2_lvl_o
);
   // Host drives the enable pin directly
   assign en_pin_o = en_req_i;
   // Loads carry a pull-up, so a released pin reads high
   assign aux1_lvl_o = aux1_oe_i ? aux1_i : 1'b1;
   assign aux2_lvl_o = aux2_oe_i ? aux2_i : 1'b1;
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   import esd_pkg::*;
   localparam int STEP = 4;
   logic clk, rstn, en_req, en_pin, wr, rd, lvl1, lvl2;
   logic [7:0] addr, wdata, rdata;
   logic reg1_en, a1, a1_oe, a2, a2_oe, pfunc, enable_pin_pulldown, sh_pd, therm, spread;
   int fails, checked, cycles, m;
   int g[3];

   esd_seq_top #(.STEP_CYCLES_P(STEP)) DUT (
      .MCLK_I(clk), .RESETN_I(rstn), .ENABLE_PIN_I(en_pin),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .LINEAR_REG_1_EN_O(reg1_en), .AUX_OUTPUT_1_O(a1), .AUX_OUTPUT_1_OE_O(a1_oe),
      .AUX_OUTPUT_2_O(a2), .AUX_OUTPUT_2_OE_O(a2_oe), .SHARED_PIN_FUNCTION_O(pfunc),
      .ENABLE_PIN_PULLDOWN_O(enable_pin_pulldown), .SHARED_PIN_PULLDOWN_O(sh_pd),
      .THERMAL_WARN_THRESHOLD_O(therm), .SPREAD_SWITCHING_ENABLE_O(spread)
   );

   esd_load_model LOADS (
      .en_req_i(en_req), .en_pin_o(en_pin), .aux1_i(a1), .aux1_oe_i(a1_oe),
      .aux2_i(a2), .aux2_oe_i(a2_oe), .aux1_lvl_o(lvl1), .aux2_lvl_o(lvl2)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_of_test;
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Moves the enable pin and records when each output first reaches the new level
   task automatic edge_run(input logic v);
      g = '{-1, -1, -1};
      @(posedge clk);
      en_req <= v;
      for (int n = 1; n <= 200; n++) begin
         @(posedge clk);
         #1;
         if (g[0] < 0 && reg1_en === v) g[0] = n;
         if (g[1] < 0 && lvl1 === v) g[1] = n;
         if (g[2] < 0 && lvl2 === v) g[2] = n;
      end
   endtask

   initial begin
      fails = 0;
      checked = 0;
      cycles = 0;
      rstn = 1'b0;
      en_req = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      // Reset values and unmapped place
      chk({pfunc, sh_pd, enable_pin_pulldown, therm, spread}, 5'b00110);
      rd_chk(8'h0f, 8'h25);
      rd_chk(8'h10, 8'h07);
      rd_chk(8'h11, 8'h0a);
      rd_chk(8'h12, 8'h77);
      rd_chk(8'h13, 8'h06);
      wr_reg(8'h14, 8'hff);
      rd_chk(8'h14, 8'h00);
      // Read-only zeros in output control, config bits to pins
      wr_reg(8'h12, 8'hff);
      rd_chk(8'h12, 8'h77);
      wr_reg(8'h12, 8'h77);
      wr_reg(8'h13, 8'h99);
      rd_chk(8'h13, 8'h99);
      chk({pfunc, sh_pd, enable_pin_pulldown, therm, spread}, 5'b11001);
      // Delay codes, both ranges, boundary codes 0 and 15
      wr_reg(8'h0f, 8'h31);
      wr_reg(8'h10, 8'h02);
      wr_reg(8'h11, 8'h4f);
      for (int r = 0; r < 2; r++) begin
         m = r + 1;
         wr_reg(8'h13, r ? 8'h60 : 8'h00);
         edge_run(1'b1);
         chk(g[0], 1 * m * STEP + 2);
         chk(g[1], 2 * m * STEP + 2);
         chk(g[2], 15 * m * STEP + 2);
         edge_run(1'b0);
         chk(g[0], 3 * m * STEP + 2);
         chk(g[1], 2);
         chk(g[2], 4 * m * STEP + 2);
      end
      // A fall before the rise completes cancels the rise
      wr_reg(8'h13, 8'h00);
      @(posedge clk);
      en_req <= 1'b1;
      repeat (3) @(posedge clk);
      en_req <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk({reg1_en, lvl1, lvl2}, 3'b000);
      repeat (32) @(posedge clk);
      #1;
      chk({reg1_en, lvl1, lvl2}, 3'b000);
      // Zero codes act on the next cycle
      wr_reg(8'h0f, 8'h00);
      wr_reg(8'h10, 8'h00);
      wr_reg(8'h11, 8'h00);
      wr_reg(8'h12, 8'h33);
      edge_run(1'b1);
      chk(g[0], 2);
      chk(g[1], 2);
      chk(g[2], 2);
      edge_run(1'b0);
      chk(g[0], 2);
      chk(g[1], 2);
      chk(g[2], 2);
      // Level, gating and drive type
      wr_reg(8'h12, 8'h11);
      chk({lvl1, a1_oe, lvl2, a2_oe}, 4'b1111);
      wr_reg(8'h12, 8'h00);
      chk({lvl1, a1_oe, lvl2, a2_oe}, 4'b0101);
      wr_reg(8'h12, 8'h77);
      chk({a1, a1_oe, a2, a2_oe}, 4'b0101);
      wr_reg(8'h12, 8'h55);
      chk({a1, a1_oe, lvl1, a2, a2_oe, lvl2}, 6'b001001);
      wr_reg(8'h12, 8'h11);
      wr_reg(8'h13, 8'h10);
      chk({a2, a2_oe, lvl1}, 3'b001);
      end_of_test();
   end
endmodule
